// ===== include/scan_ctl_pkg.sv
// Package for the eye-scan control register bank: register indices,
// field widths, reset values, scan modes and the carrier structs.
// Assumes a 32-bit AHB-Lite register port with one word per register.
package scan_ctl_pkg;

	localparam int LANES     = 16;
	localparam int PHASE_W   = 7;
	localparam int VOLT_W    = 6;
	localparam int BITPOS_W  = 5;
	localparam int MODE_W    = 4;
	localparam int COUNT_W   = 16;
	localparam int IRQ_W     = 3;
	localparam int IDX_W     = 10;
	localparam int IDX_LSB   = 2;
	localparam int IDX_MSB   = 11;
	localparam int LANE_W    = 4;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_RUN      = 10'h1F0;
	localparam logic [IDX_W-1:0] IDX_MODE     = 10'h1F1;
	localparam logic [IDX_W-1:0] IDX_PHASE    = 10'h1F2;
	localparam logic [IDX_W-1:0] IDX_VOLT     = 10'h1F3;
	localparam logic [IDX_W-1:0] IDX_BITPOS   = 10'h1F4;
	localparam logic [IDX_W-1:0] IDX_CLR      = 10'h1F5;
	localparam logic [IDX_W-1:0] IDX_DONE     = 10'h1F6;
	localparam logic [IDX_W-1:0] IDX_OUTCOME  = 10'h200;
	localparam logic [IDX_W-1:0] IDX_COUNT    = 10'h210;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h240;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h241;

	localparam logic [PHASE_W-1:0]  PHASE_RST  = 7'h00;
	localparam logic [VOLT_W-1:0]   VOLT_RST   = 6'h00;
	localparam logic [BITPOS_W-1:0] BITPOS_RST = 5'h00;
	localparam logic [BITPOS_W-1:0] BITPOS_MAX = 5'h13;
	localparam logic [IRQ_W-1:0]    IRQ_RST    = 3'h0;

	localparam int IRQ_ALL_DONE = 0;
	localparam int IRQ_CLEARED  = 1;
	localparam int IRQ_REFUSED  = 2;

	typedef enum logic [MODE_W-1:0] {
		MODE_OFF        = 4'h0,
		MODE_COMPARE    = 4'h1,
		MODE_CMP_ZERO   = 4'h2,
		MODE_CMP_ONE    = 4'h3,
		MODE_COUNT_ONE  = 4'h4,
		MODE_AVG_ZERO   = 4'h8,
		MODE_OUTER_ZERO = 4'h9,
		MODE_INNER_ZERO = 4'hA,
		MODE_AVG_ONE    = 4'hC,
		MODE_OUTER_ONE  = 4'hD,
		MODE_INNER_ONE  = 4'hE
	} scan_mode_e;

	// Settings presented to the eye-scan samplers of all lanes
	typedef struct packed {
		logic                       run;
		logic [MODE_W-1:0]          mode;
		logic signed [PHASE_W-1:0]  phase;
		logic signed [VOLT_W-1:0]   voltage;
		logic [BITPOS_W-1:0]        bit_pos;
	} scan_cfg_s;

	// Per-lane results; done is a one-cycle pulse per lane
	typedef struct packed {
		logic [LANES-1:0]              done;
		logic [LANES-1:0][VOLT_W-1:0]  voltage;
		logic [LANES-1:0][COUNT_W-1:0] count;
	} lane_report_s;

	function automatic logic mode_searches(input logic [MODE_W-1:0] m);
		return m == MODE_AVG_ZERO || m == MODE_OUTER_ZERO || m == MODE_INNER_ZERO
			|| m == MODE_AVG_ONE || m == MODE_OUTER_ONE || m == MODE_INNER_ONE;
	endfunction

	function automatic logic mode_legal(input logic [MODE_W-1:0] m);
		return m == MODE_OFF || m == MODE_COMPARE || m == MODE_CMP_ZERO
			|| m == MODE_CMP_ONE || m == MODE_COUNT_ONE || mode_searches(m);
	endfunction

endpackage

// ===== rtl/lane_result_bank.sv
// Per-lane completion flags and captured results of the eye-scan.
// Assumes lane reports come from logic on hclk; done pulses last one cycle.
`timescale 1ns/100ps
module lane_result_bank
	import scan_ctl_pkg::*;
(
	input  wire logic                                    hclk,
	input  wire logic                                    hresetn,
	input  wire logic                                    start,
	input  wire logic                                    clear_counts,
	input  wire scan_ctl_pkg::lane_report_s              rep,
	output logic [scan_ctl_pkg::LANES-1:0]               done_q,
	output logic [scan_ctl_pkg::LANES-1:0][scan_ctl_pkg::VOLT_W-1:0]  outcome_q,
	output logic [scan_ctl_pkg::LANES-1:0][scan_ctl_pkg::COUNT_W-1:0] count_q
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	genvar n;
	generate
		for (n = 0; n < LANES; n++)
		begin : g_lane
			logic               done_d;
			logic [COUNT_W-1:0] count_d;

			// A lane finishing in the start cycle keeps its flag
			assign done_d  = rep.done[n] | (done_q[n] & ~start);
			assign count_d = rep.done[n] ? rep.count[n] :
				(clear_counts ? '0 : count_q[n]);

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					done_q[n]    <= 1'b0;
					outcome_q[n] <= '0;
					count_q[n]   <= '0;
				end
				else
				begin
					done_q[n]  <= done_d;
					count_q[n] <= count_d;
					if (rep.done[n])
						outcome_q[n] <= rep.voltage[n];
				end
			end

			done_set_a: assert property (rep.done[n] |=> done_q[n] && outcome_q[n] == $past(rep.voltage[n]))
				else $error("lane done did not capture outcome");
			done_hold_a: assert property (done_q[n] && !start |=> done_q[n])
				else $error("lane done flag dropped without start");
			count_clear_a: assert property (clear_counts && !rep.done[n] |=> count_q[n] == '0)
				else $error("lane count not cleared");
		end
	endgenerate

endmodule

// ===== rtl/scan_ctl_regs.sv
// Eye-scan control register bank: AHB-Lite slave, scan settings shared by
// all lanes, completion flags, per-lane outcomes and an interrupt.
// Assumes a single AHB-Lite master on hclk and lane result logic on hclk.
//
// Operation
// - Phase offset is signed, -64 to +63
// - Phase step 1/32 UI, shared by lanes
// - Voltage offset signed, -32 to +31
// - One voltage offset serves all lanes
// - Searching modes ignore programmed voltage offset
// - Bit position selects one of twenty
// - Write one then zero clears counters
// - Sixteen read-only per-lane completion flags
// - Found voltage offset per lane, six bits
// - Sixteen outcome locations, lane zero lowest
// - Outcome top two bits read zero
// - Setting run bit starts the scan
// - Four-bit mode; reserved codes not run
// - Per-lane sixteen-bit mismatch count readout
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
module scan_ctl_regs
	import scan_ctl_pkg::*;
(
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic                             hreadyout,
	output logic                             hresp,
	output logic [31:0]                      hrdata,
	input  wire scan_ctl_pkg::lane_report_s  lane_rep,
	output scan_ctl_pkg::scan_cfg_s          cfg_q,
	output logic                             counter_clear_q,
	output logic                             irq_q
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic                       run_q;
	logic [MODE_W-1:0]          mode_q;
	logic [PHASE_W-1:0]         phase_q;
	logic [VOLT_W-1:0]          volt_q;
	logic [BITPOS_W-1:0]        bitpos_q;
	logic                       clr_q;
	logic [IRQ_W-1:0]           stat_q;
	logic [IRQ_W-1:0]           mask_q;
	logic                       all_done_q;
	logic                       wr_pend_q;
	logic [IDX_W-1:0]           wr_idx_q;
	logic [31:0]                hrdata_q;
	logic [LANES-1:0]           done_q;
	logic [LANES-1:0][VOLT_W-1:0]  outcome_q;
	logic [LANES-1:0][COUNT_W-1:0] count_q;

	// Address phase decode
	wire                 access   = hsel & htrans[1] & hready;
	wire                 addr_hit = haddr[31:IDX_MSB+1] == '0;
	wire [IDX_W-1:0]     a_idx    = haddr[IDX_MSB:IDX_LSB];
	wire [LANE_W-1:0]    a_lane   = a_idx[LANE_W-1:0];
	wire                 a_outc   = a_idx[IDX_W-1:LANE_W] == IDX_OUTCOME[IDX_W-1:LANE_W];
	wire                 a_cnt    = a_idx[IDX_W-1:LANE_W] == IDX_COUNT[IDX_W-1:LANE_W];

	// Read selection; unmapped words read zero with an OKAY answer
	wire [31:0] rd_word =
		!addr_hit                ? '0 :
		a_idx == IDX_RUN         ? {31'h0, run_q} :
		a_idx == IDX_MODE        ? {28'h0, mode_q} :
		a_idx == IDX_PHASE       ? {25'h0, phase_q} :
		a_idx == IDX_VOLT        ? {26'h0, volt_q} :
		a_idx == IDX_BITPOS      ? {27'h0, bitpos_q} :
		a_idx == IDX_CLR         ? {31'h0, clr_q} :
		a_idx == IDX_DONE        ? {16'h0, done_q} :
		a_outc                   ? {26'h0, outcome_q[a_lane]} :
		a_cnt                    ? {16'h0, count_q[a_lane]} :
		a_idx == IDX_IRQ_STAT    ? {29'h0, stat_q} :
		a_idx == IDX_IRQ_MASK    ? {29'h0, mask_q} : '0;

	// Data phase write strobes
	wire wr_run    = wr_pend_q && wr_idx_q == IDX_RUN;
	wire wr_mode   = wr_pend_q && wr_idx_q == IDX_MODE;
	wire wr_phase  = wr_pend_q && wr_idx_q == IDX_PHASE;
	wire wr_volt   = wr_pend_q && wr_idx_q == IDX_VOLT;
	wire wr_bitpos = wr_pend_q && wr_idx_q == IDX_BITPOS;
	wire wr_clr    = wr_pend_q && wr_idx_q == IDX_CLR;
	wire wr_stat   = wr_pend_q && wr_idx_q == IDX_IRQ_STAT;
	wire wr_mask   = wr_pend_q && wr_idx_q == IDX_IRQ_MASK;

	wire [MODE_W-1:0]   new_mode   = hwdata[MODE_W-1:0];
	wire [BITPOS_W-1:0] new_bitpos = hwdata[BITPOS_W-1:0];

	// Settings are frozen during a scan so lanes never see a mid-scan change
	wire cfg_wr    = wr_mode | wr_phase | wr_volt | wr_bitpos;
	wire locked    = cfg_wr & run_q;
	wire mode_bad  = wr_mode & ~mode_legal(new_mode);
	wire pos_bad   = wr_bitpos & (new_bitpos > BITPOS_MAX);
	wire refused   = locked | mode_bad | pos_bad;
	wire take_mode = wr_mode & ~run_q & ~mode_bad;
	wire take_pos  = wr_bitpos & ~run_q & ~pos_bad;

	wire start     = wr_run & hwdata[0] & ~run_q;
	wire clr_pulse = wr_clr & ~hwdata[0] & clr_q;

	wire all_done  = &done_q;
	wire [IRQ_W-1:0] events =
		{refused, clr_pulse, all_done & ~all_done_q};
	// A new event wins over a write-one-to-clear in the same cycle
	wire [IRQ_W-1:0] stat_d =
		(stat_q & ~(wr_stat ? hwdata[IRQ_W-1:0] : IRQ_RST)) | events;

	// Reserved modes never reach the samplers, and searching modes
	// find their own threshold
	wire       search   = mode_searches(mode_q);
	wire       run_eff  = run_q & (mode_q != MODE_OFF) & mode_legal(mode_q);
	scan_cfg_s cfg_d;
	assign cfg_d.run     = run_eff;
	assign cfg_d.mode    = mode_q;
	assign cfg_d.phase   = phase_q;
	assign cfg_d.voltage = search ? VOLT_RST : volt_q;
	assign cfg_d.bit_pos = bitpos_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= '0;
			hrdata_q  <= '0;
		end
		else
		begin
			wr_pend_q <= access & hwrite & addr_hit;
			wr_idx_q  <= a_idx;
			if (access & ~hwrite)
				hrdata_q <= rd_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			run_q    <= 1'b0;
			mode_q   <= MODE_OFF;
			phase_q  <= PHASE_RST;
			volt_q   <= VOLT_RST;
			bitpos_q <= BITPOS_RST;
			clr_q    <= 1'b0;
		end
		else
		begin
			if (wr_run)
				run_q <= hwdata[0];
			if (take_mode)
				mode_q <= new_mode;
			if (wr_phase & ~run_q)
				phase_q <= hwdata[PHASE_W-1:0];
			if (wr_volt & ~run_q)
				volt_q <= hwdata[VOLT_W-1:0];
			if (take_pos)
				bitpos_q <= new_bitpos;
			if (wr_clr)
				clr_q <= hwdata[0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stat_q          <= IRQ_RST;
			mask_q          <= IRQ_RST;
			all_done_q      <= 1'b0;
			irq_q           <= 1'b0;
			counter_clear_q <= 1'b0;
			cfg_q           <= '0;
		end
		else
		begin
			stat_q          <= stat_d;
			if (wr_mask)
				mask_q <= hwdata[IRQ_W-1:0];
			all_done_q      <= all_done;
			irq_q           <= |(stat_q & mask_q);
			counter_clear_q <= clr_pulse;
			cfg_q           <= cfg_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	lane_result_bank u_lanes (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.start        (start),
		.clear_counts (clr_pulse),
		.rep          (lane_rep),
		.done_q       (done_q),
		.outcome_q    (outcome_q),
		.count_q      (count_q)
	);

	phase_lock_a: assert property (run_q && wr_phase |=> phase_q == $past(phase_q))
		else $error("phase offset changed during scan");
	volt_ignore_a: assert property (mode_searches(cfg_q.mode) |-> cfg_q.voltage == VOLT_RST)
		else $error("programmed voltage reached samplers in search mode");
	volt_apply_a: assert property (!search |=> cfg_q.voltage == $past(volt_q))
		else $error("voltage offset not presented");
	phase_apply_a: assert property (##1 cfg_q.phase == $past(phase_q))
		else $error("phase offset not presented");
	bitpos_range_a: assert property (bitpos_q <= BITPOS_MAX && cfg_q.bit_pos <= BITPOS_MAX)
		else $error("bit position out of range");
	clear_pulse_a: assert property (clr_pulse |=> counter_clear_q ##1 !counter_clear_q)
		else $error("counter clear pulse wrong");
	start_flags_a: assert property (start && lane_rep.done == '0 |=> done_q == '0)
		else $error("completion flags not cleared at start");
	reserved_run_a: assert property (cfg_q.run |-> mode_legal(cfg_q.mode) && cfg_q.mode != MODE_OFF)
		else $error("scan run with reserved or off mode");
	outcome_rsvd_a: assert property (access && !hwrite && a_outc |=> hrdata_q[7:6] == 2'b00)
		else $error("outcome reserved bits not zero");
	irq_level_a: assert property ((|(stat_q & mask_q)) |=> irq_q)
		else $error("interrupt not raised");
	irq_low_a: assert property (!(|(stat_q & mask_q)) |=> !irq_q)
		else $error("interrupt raised with nothing pending");
	// An event in the same cycle as its clear must still leave the bit set
	stat_set_a: assert property ((|events) |=> (stat_q & $past(events)) == $past(events))
		else $error("status event lost");
	run_start_a: assert property (start |=> run_q)
		else $error("run bit not set by start");

endmodule

// ===== test/serdes_eye_scan_control_tb_top.sv
// Self-checking bench for the eye-scan control register bank.
// Assumes the bank is the only AHB-Lite slave, its hreadyout fed back as hready.
`timescale 1ns/100ps
module serdes_eye_scan_control_tb_top;
	import scan_ctl_pkg::*;

	logic          hclk = 1'b0;
	logic          hresetn = 1'b0;
	logic          hsel = 1'b0;
	logic [31:0]   haddr = 32'h0;
	logic [1:0]    htrans = 2'h0;
	logic          hwrite = 1'b0;
	logic [2:0]    hsize = 3'h2;
	logic [31:0]   hwdata = 32'h0;
	wire logic     hready;
	logic          hresp;
	logic [31:0]   hrdata;
	lane_report_s  lane_rep = '0;
	lane_report_s  rv;
	scan_cfg_s     cfg_q;
	logic          counter_clear_q;
	logic          irq_q;
	logic [31:0]   rd;
	logic [3:0]    m_exp;
	int            miscompares = 0;
	int            checks = 0;
	int            clr_pulses = 0;

	// Plain rows: write a word, read it back; the second phase and voltage rows write reserved bits as ones
	localparam int NR = 10;
	logic [IDX_W-1:0] r_idx [NR] = '{IDX_PHASE, IDX_PHASE, IDX_VOLT, IDX_VOLT, IDX_BITPOS,
		IDX_BITPOS, IDX_DONE, IDX_OUTCOME + 10'h00F, 10'h3FF, IDX_IRQ_MASK};
	logic [31:0] r_wd [NR] = '{32'h3F, 32'hFFFFFFC0, 32'h1F, 32'hFFFFFFE0, 32'h13,
		32'h14, 32'hFFFF, 32'h3F, 32'h5A5A5A5A, 32'h7};
	logic [31:0] r_exp [NR] = '{32'h3F, 32'h40, 32'h1F, 32'h20, 32'h13,
		32'h13, 32'h0, 32'h0, 32'h0, 32'h7};

	scan_ctl_regs dut (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.hsel            (hsel),
		.haddr           (haddr),
		.htrans          (htrans),
		.hwrite          (hwrite),
		.hsize           (hsize),
		.hwdata          (hwdata),
		.hready          (hready),
		.hreadyout       (hready),
		.hresp           (hresp),
		.hrdata          (hrdata),
		.lane_rep        (lane_rep),
		.cfg_q           (cfg_q),
		.counter_clear_q (counter_clear_q),
		.irq_q           (irq_q)
	);

	always #12.5 hclk = ~hclk;

	always @(posedge hclk)
		if (counter_clear_q === 1'b1)
			clr_pulses <= clr_pulses + 1;

	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Bounded wait for hready; a stuck bus ends the run
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1)
		begin
			miscompares++;
			$display("wrong value hready expected 1 seen %b", hready);
			tally_and_finish();
		end
	endtask

	task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {20'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic rchk(input string nm, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk(nm, exp, rd);
	endtask

	// One-cycle done pulse on the masked lanes, results valid alongside it
	task automatic lanes(input logic [LANES-1:0] msk, input logic [VOLT_W-1:0] vb);
		@(posedge hclk);
		for (int n = 0; n < LANES; n++)
		begin
			rv.voltage[n] = vb + VOLT_W'(n);
			rv.count[n]   = 16'hA500 + 16'(n);
		end
		rv.done = msk;
		lane_rep <= rv;
		@(posedge hclk);
		lane_rep.done <= '0;
	endtask

	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < NR; i++)
		begin
			bus(1'b1, r_idx[i], r_wd[i]);
			rchk("row readback", r_idx[i], r_exp[i]);
		end
		chk("cfg phase", 32'h40, {25'h0, cfg_q.phase});
		chk("cfg voltage", 32'h20, {26'h0, cfg_q.voltage});
		chk("cfg bit position", 32'h13, {27'h0, cfg_q.bit_pos});
		chk("irq on refusal", 32'h1, {31'h0, irq_q});
		chk("hresp okay", 32'h0, {31'h0, hresp});
		// Software sweep over every legal bit position
		for (int p = 0; p < 20; p++)
		begin
			bus(1'b1, IDX_BITPOS, 32'(p));
			rchk("bit sweep", IDX_BITPOS, 32'(p));
		end
		$display("test table done");

		bus(1'b1, IDX_IRQ_STAT, 32'h7);
		m_exp = 4'h0;
		for (int m = 0; m < 16; m++)
		begin
			if (m < 5 || (m > 7 && m < 15 && m != 11))
				m_exp = 4'(m);
			bus(1'b1, IDX_MODE, 32'(m));
			rchk("mode", IDX_MODE, {28'h0, m_exp});
			chk("cfg voltage", (m_exp > 4'h7) ? 32'h0 : 32'h20, {26'h0, cfg_q.voltage});
		end
		rchk("refusal status", IDX_IRQ_STAT, 32'h4);
		bus(1'b1, IDX_IRQ_STAT, 32'h4);
		rchk("status cleared", IDX_IRQ_STAT, 32'h0);
		chk("irq cleared", 32'h0, {31'h0, irq_q});
		$display("test modes done");

		// Stale flags from an earlier pass must vanish at the start
		bus(1'b1, IDX_MODE, 32'h1);
		lanes(16'hFFFF, 6'h00);
		rchk("done all", IDX_DONE, 32'hFFFF);
		rchk("status all done", IDX_IRQ_STAT, 32'h1);
		bus(1'b1, IDX_RUN, 32'h1);
		rchk("done after start", IDX_DONE, 32'h0);
		chk("cfg run", 32'h1, {31'h0, cfg_q.run});
		chk("cfg mode", 32'h1, {28'h0, cfg_q.mode});
		bus(1'b1, IDX_PHASE, 32'h05);
		rchk("phase locked", IDX_PHASE, 32'h40);
		lanes(16'h8001, 6'h30);
		rchk("done two", IDX_DONE, 32'h8001);
		rchk("outcome lane 0", IDX_OUTCOME, 32'h30);
		rchk("outcome lane 15", IDX_OUTCOME + 10'h00F, 32'h3F);
		rchk("count lane 15", IDX_COUNT + 10'h00F, 32'hA50F);
		bus(1'b1, IDX_RUN, 32'h0);
		$display("test run done");

		bus(1'b1, IDX_CLR, 32'h1);
		bus(1'b1, IDX_CLR, 32'h0);
		rchk("count cleared", IDX_COUNT + 10'h00F, 32'h0);
		chk("clear pulses", 32'h1, 32'(clr_pulses));
		rchk("status after clear", IDX_IRQ_STAT, 32'h7);
		$display("test counter clear done");

		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		chk("reset cfg", 32'h0, 32'(cfg_q));
		rchk("reset phase", IDX_PHASE, 32'h0);
		rchk("reset done", IDX_DONE, 32'h0);
		$display("test reset done");
		tally_and_finish();
	end
endmodule
